/* File: nsx_pkg.sv */
// Package: opcode patterns, field positions and reset values for the four-operation decoder
package nsx_pkg;
    // ***************************************
    // Instruction word layout
    // ***************************************
    localparam int INSTR_W = 12;
    localparam int DATA_W = 8;
    localparam int FADDR_W = 5;
    localparam int DEST_BIT = 5;
    localparam int DIR_SEL_W = 3;

    // ***************************************
    // Opcode patterns
    // ***************************************
    localparam logic [5:0] NIBBLE_EXCHANGE_TOP = 6'h0e;  // 0011 10
    localparam logic [5:0] REGISTER_XOR_TOP = 6'h06;     // 0001 10
    localparam logic [3:0] LITERAL_XOR_TOP = 4'hf;       // 1111
    localparam logic [8:0] DIRECTION_LOAD_TOP = 9'h000;  // 0000 0000 0
    localparam logic [2:0] DIR_SEL_SECOND_PORT = 3'h6;
    localparam logic [2:0] DIR_SEL_SEVEN = 3'h7;

    // ***************************************
    // Reset values
    // ***************************************
    localparam logic [7:0] W_RESET = 8'h00;
    localparam logic [7:0] DIR_RESET = 8'hff;
    localparam logic [7:0] FILE_RESET = 8'h00;
    localparam int FILE_DEPTH = 32;

    typedef enum logic [2:0] {
        OP_NONE = 3'b000,
        OP_NIBBLE_EXCHANGE = 3'b001,
        OP_REGISTER_XOR = 3'b011,
        OP_LITERAL_XOR = 3'b010,
        OP_DIRECTION_LOAD = 3'b110
    } op_t;
endpackage

/* File: nibble_swap_xor_dir_decode.sv */
// Decode and single-cycle execution of nibble exchange, literal and register XOR, direction load
`timescale 1ns/1ps

module nibble_swap_xor_dir_decode #(
    parameter int DEPTH = nsx_pkg::FILE_DEPTH
) (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic rstn_i,
    // Instruction stream, one word per instruction cycle
    input wire logic instr_valid_i,
    input wire logic [11:0] instr_i,
    // Architectural state seen by the rest of the core
    output logic [7:0] w_o,
    output logic zero_o,
    output logic [7:0] second_port_dir_o,
    output logic [7:0] aux_dir_o,
    output logic [7:0] file_data_o,
    output logic [4:0] file_addr_o,
    output logic file_we_o,
    output logic illegal_o
);

    // ***************************************
    // State
    // ***************************************
    typedef struct packed {
        logic [7:0] w;
        logic zero;
        logic [7:0] dir6;
        logic [7:0] dir7;
        logic [7:0] fdata;
        logic [4:0] faddr;
        logic fwe;
        logic illegal;
    } state_t;

    state_t s_q;
    state_t s_d;
    logic [7:0] file_q [DEPTH];
    logic [DEPTH-1:0] entry_we;

    nsx_pkg::op_t op;
    logic [4:0] faddr;
    logic dest;
    logic [2:0] dir_sel;
    logic [7:0] lit_byte;
    logic [7:0] fval;
    logic [7:0] res;
    logic [7:0] swap_res;
    logic [7:0] lxor_res;
    logic [7:0] rxor_res;
    logic lxor_zero;
    logic rxor_zero;
    logic sel_second_port;
    logic sel_aux;
    logic hit_literal_xor;
    logic hit_nibble_exchange;
    logic hit_register_xor;
    logic hit_direction_load;

    // ***************************************
    // Operand fields
    // ***************************************
    assign faddr = instr_i[nsx_pkg::FADDR_W-1:0];
    assign dest = instr_i[nsx_pkg::DEST_BIT];
    assign dir_sel = instr_i[nsx_pkg::DIR_SEL_W-1:0];
    assign lit_byte = instr_i[nsx_pkg::DATA_W-1:0];
    // Combinational read so a write-back is seen by the very next word
    assign fval = file_q[faddr];

    // ***************************************
    // Opcode matches
    // ***************************************
    assign hit_literal_xor = (instr_i[11:8] == nsx_pkg::LITERAL_XOR_TOP);
    assign hit_nibble_exchange = (instr_i[11:6] == nsx_pkg::NIBBLE_EXCHANGE_TOP);
    assign hit_register_xor = (instr_i[11:6] == nsx_pkg::REGISTER_XOR_TOP);
    assign hit_direction_load = (instr_i[11:3] == nsx_pkg::DIRECTION_LOAD_TOP);

    // ***************************************
    // Operation results
    // ***************************************
    assign swap_res = {fval[3:0], fval[7:4]};
    assign lxor_res = s_q.w ^ lit_byte;
    assign rxor_res = s_q.w ^ fval;
    assign lxor_zero = (lxor_res == 8'h00);
    assign rxor_zero = (rxor_res == 8'h00);

    // ***************************************
    // Direction selectors
    // ***************************************
    // Selector 6 is the second port, 7 the auxiliary register
    assign sel_second_port = (dir_sel == nsx_pkg::DIR_SEL_SECOND_PORT);
    assign sel_aux = (dir_sel == nsx_pkg::DIR_SEL_SEVEN);

    // ***************************************
    // Decode
    // ***************************************
    always_comb begin
        op = nsx_pkg::OP_NONE;
        // Patterns never overlap; the order only matters if the table grows
        if (hit_literal_xor) begin
            op = nsx_pkg::OP_LITERAL_XOR;
        end else if (hit_nibble_exchange) begin
            op = nsx_pkg::OP_NIBBLE_EXCHANGE;
        end else if (hit_register_xor) begin
            op = nsx_pkg::OP_REGISTER_XOR;
        end else if (hit_direction_load) begin
            op = nsx_pkg::OP_DIRECTION_LOAD;
        end
    end

    // ***************************************
    // Execute, all in one cycle
    // ***************************************
    always_comb begin
        s_d = s_q;
        // Pulses drop unless this word raises them again
        s_d.fwe = 1'b0;
        s_d.illegal = 1'b0;
        res = 8'h00;
        if (instr_valid_i) begin
            case (op)
                nsx_pkg::OP_NIBBLE_EXCHANGE: begin
                    res = swap_res;
                    if (dest) begin
                        s_d.fwe = 1'b1;
                        s_d.faddr = faddr;
                        s_d.fdata = res;
                    end else begin
                        s_d.w = res;
                    end
                end
                nsx_pkg::OP_REGISTER_XOR: begin
                    res = rxor_res;
                    s_d.zero = rxor_zero;
                    if (dest) begin
                        s_d.fwe = 1'b1;
                        s_d.faddr = faddr;
                        s_d.fdata = res;
                    end else begin
                        s_d.w = res;
                    end
                end
                nsx_pkg::OP_LITERAL_XOR: begin
                    res = lxor_res;
                    s_d.w = res;
                    s_d.zero = lxor_zero;
                end
                nsx_pkg::OP_DIRECTION_LOAD: begin
                    // Other selectors are not direction registers here; flagged, nothing changes
                    if (sel_second_port) begin
                        s_d.dir6 = s_q.w;
                    end else if (sel_aux) begin
                        s_d.dir7 = s_q.w;
                    end else begin
                        s_d.illegal = 1'b1;
                    end
                end
                default: begin
                    // Rest of the instruction set lives elsewhere
                end
            endcase
        end
    end

    // ***************************************
    // Registers
    // ***************************************
    // Everything but the file lives in one struct so reset and update stay in step
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            s_q.w <= nsx_pkg::W_RESET;
            s_q.zero <= 1'b0;
            s_q.dir6 <= nsx_pkg::DIR_RESET;
            s_q.dir7 <= nsx_pkg::DIR_RESET;
            s_q.fdata <= nsx_pkg::FILE_RESET;
            s_q.faddr <= 5'h00;
            s_q.fwe <= 1'b0;
            s_q.illegal <= 1'b0;
        end else begin
            s_q <= s_d;
        end
    end

    // ***************************************
    // File registers
    // ***************************************
    // Cleared at reset: every write-back reads its own cell first, so an unset cell could never become known
    generate
        for (genvar i = 0; i < DEPTH; i++) begin : g_file
            assign entry_we[i] = instr_valid_i && s_d.fwe && (faddr == 5'(i));
            always_ff @(posedge ref_clk_i or negedge rstn_i) begin
                if (!rstn_i) begin
                    file_q[i] <= nsx_pkg::FILE_RESET;
                end else if (entry_we[i]) begin
                    file_q[i] <= res;
                end
            end
        end
    endgenerate

    // ***************************************
    // Outputs
    // ***************************************
    // Every output leaves straight from a register
    assign w_o = s_q.w;
    assign zero_o = s_q.zero;
    assign second_port_dir_o = s_q.dir6;
    assign aux_dir_o = s_q.dir7;
    assign file_data_o = s_q.fdata;
    assign file_addr_o = s_q.faddr;
    assign file_we_o = s_q.fwe;
    assign illegal_o = s_q.illegal;

endmodule // nibble_swap_xor_dir_decode

/* File: nsx_props.sv */
// Assertion checker for the four-operation decoder
`timescale 1ns/1ps
module nsx_props (
    input wire logic ref_clk_i, rstn_i, instr_valid_i, zero_o, file_we_o, illegal_o,
    input wire logic [11:0] instr_i,
    input wire logic [7:0] w_o, second_port_dir_o, aux_dir_o, file_data_o,
    input wire logic [4:0] file_addr_o
);
    default clocking @(posedge ref_clk_i);
    endclocking
    default disable iff (!rstn_i);
    wire lx = instr_valid_i && instr_i[11:8] == 4'hf;
    wire sw = instr_valid_i && instr_i[11:6] == 6'h0e;
    wire rx = instr_valid_i && instr_i[11:6] == 6'h06;
    wire dl = instr_valid_i && instr_i[11:3] == 9'h000;
    lxor_value_a: assert property (lx |=> w_o == ($past(w_o) ^ $past(instr_i[7:0])))
        else $error("literal xor result wrong");
    lxor_zero_a: assert property (lx |=> zero_o == (w_o == 8'h00))
        else $error("literal xor zero flag wrong");
    swap_flags_a: assert property (sw |=> $stable(zero_o))
        else $error("swap changed zero flag");
    swap_keepw_a: assert property (sw && instr_i[5] |=> file_we_o && $stable(w_o))
        else $error("swap to file went wrong");
    rxor_dest_a: assert property (rx |=> file_we_o == $past(instr_i[5]))
        else $error("register xor destination wrong");
    rxor_zero_a: assert property (rx && !instr_i[5] |=> zero_o == (w_o == 8'h00))
        else $error("register xor zero flag wrong");
    wb_addr_a: assert property (file_we_o |-> file_addr_o == $past(instr_i[4:0]))
        else $error("write-back address wrong");
    dir_load_a: assert property (dl && instr_i[2:0] == 3'h6 |=> second_port_dir_o == $past(w_o))
        else $error("direction load wrong");
    dir_aux_a: assert property (dl && instr_i[2:0] == 3'h7 |=> aux_dir_o == $past(w_o))
        else $error("second direction load wrong");
    idle_hold_a: assert property (!instr_valid_i |=> !file_we_o && $stable(w_o))
        else $error("state changed without instruction");
    cover property (lx ##1 lx);
    cover property (sw && instr_i[5]);
    cover property (dl ##1 illegal_o);
    cover property (rx && !instr_i[5]);
endmodule // nsx_props

bind nibble_swap_xor_dir_decode nsx_props i_nsx_props (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i),
    .instr_valid_i(instr_valid_i), .zero_o(zero_o), .file_we_o(file_we_o), .illegal_o(illegal_o),
    .instr_i(instr_i), .w_o(w_o), .second_port_dir_o(second_port_dir_o), .aux_dir_o(aux_dir_o),
    .file_data_o(file_data_o), .file_addr_o(file_addr_o));

/* File: test_nibble_swap_xor_dir_decode.sv */
// Testbench for the four-operation decoder
`timescale 1ns/1ps
module test_nibble_swap_xor_dir_decode;
    logic ref_clk_i = 1'b0;
    logic rstn_i = 1'b0;
    logic instr_valid_i = 1'b0;
    logic [11:0] instr_i = 12'h000;
    logic [7:0] w_o, second_port_dir_o, aux_dir_o, file_data_o;
    logic [4:0] file_addr_o;
    logic zero_o, file_we_o, illegal_o;
    int n_errors = 0;
    int n_compared = 0;
    always #5 ref_clk_i = ~ref_clk_i;
    nibble_swap_xor_dir_decode i_nibble_swap_xor_dir_decode (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i),
        .instr_valid_i(instr_valid_i), .instr_i(instr_i), .w_o(w_o), .zero_o(zero_o),
        .second_port_dir_o(second_port_dir_o), .aux_dir_o(aux_dir_o), .file_data_o(file_data_o),
        .file_addr_o(file_addr_o), .file_we_o(file_we_o), .illegal_o(illegal_o));
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_errors++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Valid stays up between calls so back-to-back words never toggle it
    task automatic exec(input logic [11:0] word);
        instr_i = word;
        instr_valid_i = 1'b1;
        @(negedge ref_clk_i);
    endtask
    task automatic idle();
        instr_valid_i = 1'b0;
        @(negedge ref_clk_i);
    endtask
    task automatic t_literal();
        exec(12'hfb5);
        check(w_o, 8'hb5);
        exec(12'hfaf);
        check(w_o, 8'h1a);
        check({7'h00, zero_o}, 8'h00);
        exec(12'hf1a);
        check({7'h00, zero_o}, 8'h01);
        idle();
        $display("literal xor test done");
    endtask
    task automatic t_direction();
        check(second_port_dir_o, 8'hff);
        exec(12'hfa5);
        exec(12'h006);
        check(second_port_dir_o, 8'ha5);
        exec(12'hf0f);
        exec(12'h007);
        check(aux_dir_o, 8'haa);
        exec(12'h005);
        check({7'h00, illegal_o}, 8'h01);
        check(second_port_dir_o, 8'ha5);
        idle();
        $display("direction load test done");
    endtask
    // File cells start cleared, so every step below has a known operand
    task automatic t_file();
        exec(12'hf0f);
        exec(12'h1a3);
        check({3'h0, file_addr_o}, 8'h03);
        check({7'h00, file_we_o}, 8'h01);
        check(file_data_o, 8'ha5);
        check(w_o, 8'ha5);
        exec(12'h183);
        check(w_o, 8'h00);
        check({7'h00, zero_o}, 8'h01);
        check({7'h00, file_we_o}, 8'h00);
        exec(12'h3a3);
        check(file_data_o, 8'h5a);
        check({7'h00, file_we_o}, 8'h01);
        check(w_o, 8'h00);
        exec(12'h383);
        check(w_o, 8'ha5);
        check({7'h00, zero_o}, 8'h01);
        exec(12'h1bf);
        check({3'h0, file_addr_o}, 8'h1f);
        check(file_data_o, 8'ha5);
        check({7'h00, zero_o}, 8'h00);
        exec(12'h39f);
        check(w_o, 8'h5a);
        idle();
        $display("file operand test done");
    endtask
    // A reset in mid-run must bring w, both direction outputs, the write-back data and address, and file cell 3 back to their start values
    task automatic t_reset();
        rstn_i = 1'b0;
        @(negedge ref_clk_i);
        check(w_o, 8'h00);
        check(second_port_dir_o, 8'hff);
        check(aux_dir_o, 8'hff);
        check(file_data_o, 8'h00);
        check({3'h0, file_addr_o}, 8'h00);
        rstn_i = 1'b1;
        @(negedge ref_clk_i);
        exec(12'hf3c);
        check(w_o, 8'h3c);
        exec(12'h383);
        check(w_o, 8'h00);
        idle();
        $display("reset test done");
    endtask
    task automatic give_verdict();
        $display("compared %0d mismatches %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    initial begin
        repeat (10) @(negedge ref_clk_i);
        rstn_i = 1'b1;
        @(negedge ref_clk_i);
        t_literal();
        t_direction();
        t_file();
        t_reset();
        give_verdict();
    end
    initial begin
        #2000;
        n_errors++;
        give_verdict();
    end
endmodule // test_nibble_swap_xor_dir_decode
